// *** pkg/dcpu_regs.vh ***
// Register map, field layouts and constants of the direct-colour pixel unpacker.
`ifndef DCPU_REGS_VH
`define DCPU_REGS_VH
`define DCPU_ADDR_CTRL 12'h000
`define DCPU_ADDR_STAT 12'h004
`define DCPU_ADDR_CAPT 12'h008
`define DCPU_CTRL_RST 32'h00000012
`define DCPU_CFG_RST 8'h12
`define DCPU_CTRL_MASK 32'h000000FF
`define DCPU_CTRL_LAYOUT 2:0
`define DCPU_CTRL_WIDTH 4:3
`define DCPU_CTRL_BE 5
`define DCPU_CTRL_TRUE 6
`define DCPU_CTRL_EN 7
`define DCPU_LAY_BGRO 3'h0
`define DCPU_LAY_ORGB 3'h1
`define DCPU_LAY_565 3'h2
`define DCPU_LAY_1555 3'h3
`define DCPU_LAY_664 3'h4
`define DCPU_LAY_4444 3'h5
`define DCPU_BW_16 2'h0
`define DCPU_BW_32 2'h1
`define DCPU_BW_64 2'h2
`define DCPU_NPIX_16 3'h1
`define DCPU_NPIX_32 3'h2
`define DCPU_NPIX_64 3'h4
`define DCPU_SLICE_16 6'h10
`define DCPU_SLICE_32 6'h20
`define DCPU_MASK_16 64'h000000000000FFFF
`define DCPU_MASK_32 64'h00000000FFFFFFFF
`define DCPU_MASK_64 64'hFFFFFFFFFFFFFFFF
`define DCPU_LO_24 5'h18
`define DCPU_LO_16 5'h10
`define DCPU_LO_12 5'h0C
`define DCPU_LO_11 5'h0B
`define DCPU_LO_10 5'h0A
`define DCPU_LO_8 5'h08
`define DCPU_LO_6 5'h06
`define DCPU_LO_5 5'h05
`define DCPU_LO_4 5'h04
`define DCPU_LO_1 5'h01
`define DCPU_LO_0 5'h00
`define DCPU_W_8 4'h8
`define DCPU_W_6 4'h6
`define DCPU_W_5 4'h5
`define DCPU_W_4 4'h4
`define DCPU_W_1 4'h1
`define DCPU_W_0 4'h0
`endif

// *** core/dcpu_buf.v ***
// Two-entry pixel buffer with valid and ready on both sides.
module dcpu_buf #(
	parameter W = 32
) (
	input wire pclk,
	input wire presetn,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg out_v_q;
	reg [W-1:0] out_d_q;
	reg skid_v_q;
	reg [W-1:0] skid_d_q;

	assign in_ready = ~skid_v_q;
	assign out_valid = out_v_q;
	assign out_data = out_d_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_v_q <= 1'b0;
			out_d_q <= {W{1'b0}};
			skid_v_q <= 1'b0;
			skid_d_q <= {W{1'b0}};
		end else if (in_valid && !skid_v_q) begin
			if (out_v_q && !out_ready) begin
				skid_d_q <= in_data;
				skid_v_q <= 1'b1;
			end else begin
				out_d_q <= in_data;
				out_v_q <= 1'b1;
			end
		end else if (out_ready || !out_v_q) begin
			if (skid_v_q) begin
				out_d_q <= skid_d_q;
				out_v_q <= 1'b1;
				skid_v_q <= 1'b0;
			end else begin
				out_v_q <= 1'b0;
			end
		end
	end
endmodule

// *** core/dcpu_top.v ***
// Pixel bus capture, direct-colour unpacking and APB control of the pixel unpacker.
//
// Added by the designer: the APB register port and the register offsets.
`include "dcpu_regs.vh"

// Summary of operation
// - Each rising edge of latch_clock while enabled captures a new bus word and restarts unpacking.
// - Pixels of one capture leave one per pixel cycle, lowest-numbered bus bits first.
// - In little-endian layouts the highest bus bit of a field is the component's MSB.
// - Big-endian words are captured and sequenced exactly like little-endian ones.
// - True-colour modes use the direct-colour layouts but ignore the overlay field.
// - In both endian orders the first 32-bit layout takes blue 31:24, green 23:16, red 15:8, overlay 7:0 per pixel.
// - Alternate 32-bit layout takes overlay 31:24, red 23:16, green 15:8, blue 7:0 per pixel.
// - Big-endian 5-6-5 takes blue from the top 5, green the middle 6, red the low 5 bits.
// - Big-endian 5-5-5 takes blue 15:11, green 10:6, red 5:1 and overlay from bit 0.
// - Big-endian 4-6-6 takes blue 15:12, green 11:6 and red 5:0 of each slice.
// - Big-endian 4-4-4-4 takes overlay 15:12, blue 11:8, green 7:4 and red 3:0.
// - Little-endian 6-6-4 takes red 15:10, green 9:4 and blue 3:0 of each slice.
// - Little-endian 4-4-4-4 takes red 15:12, green 11:8, blue 7:4 and overlay 3:0.
module dcpu_top #(
	parameter BUS_W = 64
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire latch_clock,
	input wire [BUS_W-1:0] pixel_bus,
	input wire frame_blank,
	input wire pix_ready,
	output wire pix_valid,
	output wire [7:0] pix_red,
	output wire [7:0] pix_green,
	output wire [7:0] pix_blue,
	output wire [7:0] pix_ovl
);
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	reg [31:0] ctrl_q;
	reg [7:0] cfg_q;
	reg [15:0] capt_cnt_q;
	reg [7:0] restart_cnt_q;
	reg latch_clock_s1_q, latch_clock_s2_q, latch_clock_s3_q;
	reg [BUS_W-1:0] bus_s1_q, bus_s2_q;
	reg [1:0] st_q;
	reg [1:0] st_d;
	reg [63:0] shift_q;
	reg [2:0] left_q;
	reg [31:0] rdata_d;
	reg addr_ok_d;
	reg [7:0] r_d, g_d, b_d, o_d;
	reg [2:0] npix_d;
	reg [5:0] slice_d;
	reg [63:0] mask_d;
	wire [63:0] bus_wide;
	wire latch_clock_rise;
	wire buf_ready;
	wire push;
	wire [31:0] buf_out;
	wire be;

	// Picks a field and returns it MSB-aligned; the big-endian order is reversed.
	function [7:0] fld;
		input [31:0] s;
		input [4:0] lo;
		input [3:0] w;
		input rev;
		integer k;
		reg [5:0] idx;
		begin
			fld = 8'h00;
			idx = 6'h00;
			for (k = 0; k < 8; k = k + 1) begin
				if (k < w) begin
					if (rev) begin
						idx = {1'b0, lo} + k[5:0];
					end else begin
						idx = {1'b0, lo} + {2'b00, w} - 6'h01 - k[5:0];
					end
					fld[7-k] = s[idx[4:0]];
				end
			end
		end
	endfunction

	assign be = cfg_q[`DCPU_CTRL_BE];
	assign latch_clock_rise = latch_clock_s2_q & ~latch_clock_s3_q;
	assign push = st_q[1] && (left_q != 3'h0) && buf_ready;
	// Narrow buses are padded with zeros; a zero-width pad is never built.
	generate
		if (BUS_W < 64) begin : g_pad
			assign bus_wide = {{(64-BUS_W){1'b0}}, bus_s2_q};
		end else begin : g_full
			assign bus_wide = bus_s2_q[63:0];
		end
	endgenerate
	assign pix_red = buf_out[31:24];
	assign pix_green = buf_out[23:16];
	assign pix_blue = buf_out[15:8];
	assign pix_ovl = buf_out[7:0];

	// Two-stage synchronisers for the latch clock and the pixel bus.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_clock_s1_q <= 1'b0;
			latch_clock_s2_q <= 1'b0;
			latch_clock_s3_q <= 1'b0;
			bus_s1_q <= {BUS_W{1'b0}};
			bus_s2_q <= {BUS_W{1'b0}};
		end else begin
			latch_clock_s1_q <= latch_clock;
			latch_clock_s2_q <= latch_clock_s1_q;
			latch_clock_s3_q <= latch_clock_s2_q;
			bus_s1_q <= pixel_bus;
			bus_s2_q <= bus_s1_q;
		end
	end

	// Pixel count, slice width and bus mask follow layout and bus width.
	always @* begin
		case (cfg_q[`DCPU_CTRL_WIDTH])
			`DCPU_BW_16: mask_d = `DCPU_MASK_16;
			`DCPU_BW_32: mask_d = `DCPU_MASK_32;
			default: mask_d = `DCPU_MASK_64;
		endcase
		if (cfg_q[`DCPU_CTRL_LAYOUT] == `DCPU_LAY_BGRO ||
			cfg_q[`DCPU_CTRL_LAYOUT] == `DCPU_LAY_ORGB) begin
			slice_d = `DCPU_SLICE_32;
			case (cfg_q[`DCPU_CTRL_WIDTH])
				`DCPU_BW_64: npix_d = `DCPU_NPIX_32;
				default: npix_d = `DCPU_NPIX_16;
			endcase
		end else begin
			slice_d = `DCPU_SLICE_16;
			case (cfg_q[`DCPU_CTRL_WIDTH])
				`DCPU_BW_16: npix_d = `DCPU_NPIX_16;
				`DCPU_BW_32: npix_d = `DCPU_NPIX_32;
				default: npix_d = `DCPU_NPIX_64;
			endcase
		end
	end

	// Colour fields of the pixel in the lowest slice.
	always @* begin
		r_d = 8'h00;
		g_d = 8'h00;
		b_d = 8'h00;
		o_d = 8'h00;
		case (cfg_q[`DCPU_CTRL_LAYOUT])
			`DCPU_LAY_BGRO: begin
				b_d = fld(shift_q[31:0], `DCPU_LO_24, `DCPU_W_8, be);
				g_d = fld(shift_q[31:0], `DCPU_LO_16, `DCPU_W_8, be);
				r_d = fld(shift_q[31:0], `DCPU_LO_8, `DCPU_W_8, be);
				o_d = fld(shift_q[31:0], `DCPU_LO_0, `DCPU_W_8, be);
			end
			`DCPU_LAY_ORGB: begin
				o_d = fld(shift_q[31:0], `DCPU_LO_24, `DCPU_W_8, be);
				r_d = fld(shift_q[31:0], `DCPU_LO_16, `DCPU_W_8, be);
				g_d = fld(shift_q[31:0], `DCPU_LO_8, `DCPU_W_8, be);
				b_d = fld(shift_q[31:0], `DCPU_LO_0, `DCPU_W_8, be);
			end
			`DCPU_LAY_565: begin
				g_d = fld(shift_q[31:0], `DCPU_LO_5, `DCPU_W_6, be);
				if (be) begin
					b_d = fld(shift_q[31:0], `DCPU_LO_11, `DCPU_W_5, be);
					r_d = fld(shift_q[31:0], `DCPU_LO_0, `DCPU_W_5, be);
				end else begin
					r_d = fld(shift_q[31:0], `DCPU_LO_11, `DCPU_W_5, be);
					b_d = fld(shift_q[31:0], `DCPU_LO_0, `DCPU_W_5, be);
				end
			end
			`DCPU_LAY_1555: begin
				if (be) begin
					b_d = fld(shift_q[31:0], `DCPU_LO_11, `DCPU_W_5, be);
					g_d = fld(shift_q[31:0], `DCPU_LO_6, `DCPU_W_5, be);
					r_d = fld(shift_q[31:0], `DCPU_LO_1, `DCPU_W_5, be);
					o_d = fld(shift_q[31:0], `DCPU_LO_0, `DCPU_W_1, be);
				end else begin
					o_d = fld(shift_q[31:0], `DCPU_LO_10 + `DCPU_LO_5, `DCPU_W_1, be);
					r_d = fld(shift_q[31:0], `DCPU_LO_10, `DCPU_W_5, be);
					g_d = fld(shift_q[31:0], `DCPU_LO_5, `DCPU_W_5, be);
					b_d = fld(shift_q[31:0], `DCPU_LO_0, `DCPU_W_5, be);
				end
			end
			`DCPU_LAY_664: begin
				if (be) begin
					b_d = fld(shift_q[31:0], `DCPU_LO_12, `DCPU_W_4, be);
					g_d = fld(shift_q[31:0], `DCPU_LO_6, `DCPU_W_6, be);
					r_d = fld(shift_q[31:0], `DCPU_LO_0, `DCPU_W_6, be);
				end else begin
					r_d = fld(shift_q[31:0], `DCPU_LO_10, `DCPU_W_6, be);
					g_d = fld(shift_q[31:0], `DCPU_LO_4, `DCPU_W_6, be);
					b_d = fld(shift_q[31:0], `DCPU_LO_0, `DCPU_W_4, be);
				end
			end
			`DCPU_LAY_4444: begin
				if (be) begin
					o_d = fld(shift_q[31:0], `DCPU_LO_12, `DCPU_W_4, be);
					b_d = fld(shift_q[31:0], `DCPU_LO_8, `DCPU_W_4, be);
					g_d = fld(shift_q[31:0], `DCPU_LO_4, `DCPU_W_4, be);
					r_d = fld(shift_q[31:0], `DCPU_LO_0, `DCPU_W_4, be);
				end else begin
					r_d = fld(shift_q[31:0], `DCPU_LO_12, `DCPU_W_4, be);
					g_d = fld(shift_q[31:0], `DCPU_LO_8, `DCPU_W_4, be);
					b_d = fld(shift_q[31:0], `DCPU_LO_4, `DCPU_W_4, be);
					o_d = fld(shift_q[31:0], `DCPU_LO_0, `DCPU_W_4, be);
				end
			end
			default: begin
				r_d = 8'h00;
			end
		endcase
		if (cfg_q[`DCPU_CTRL_TRUE]) begin
			o_d = 8'h00;
		end
	end

	always @* begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (latch_clock_rise && cfg_q[`DCPU_CTRL_EN]) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (push && left_q == 3'h1 && !latch_clock_rise) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// Capture, restart and pixel sequencing; both endian orders share this path.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_IDLE;
			shift_q <= 64'h0000000000000000;
			left_q <= 3'h0;
			capt_cnt_q <= 16'h0000;
			restart_cnt_q <= 8'h00;
		end else begin
			st_q <= st_d;
			if (latch_clock_rise && cfg_q[`DCPU_CTRL_EN]) begin
				shift_q <= bus_wide & mask_d;
				left_q <= npix_d;
				capt_cnt_q <= capt_cnt_q + 16'h0001;
				if (left_q != 3'h0 && !(push && left_q == 3'h1)) begin
					restart_cnt_q <= restart_cnt_q + 8'h01;
				end
			end else if (push) begin
				shift_q <= shift_q >> slice_d;
				left_q <= left_q - 3'h1;
			end
		end
	end

	dcpu_buf #(
		.W(32)
	) u_buf (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(push),
		.in_ready(buf_ready),
		.in_data({r_d, g_d, b_d, o_d}),
		.out_valid(pix_valid),
		.out_ready(pix_ready),
		.out_data(buf_out)
	);

	// APB read decode.
	always @* begin
		rdata_d = 32'h00000000;
		addr_ok_d = 1'b1;
		case (paddr)
			`DCPU_ADDR_CTRL: rdata_d = ctrl_q;
			`DCPU_ADDR_STAT: rdata_d = {16'h0000, restart_cnt_q, cfg_q};
			`DCPU_ADDR_CAPT: rdata_d = {13'h0000, left_q, capt_cnt_q};
			default: addr_ok_d = 1'b0;
		endcase
	end

	// APB slave: answers in the first access cycle; new settings wait for blanking.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `DCPU_CTRL_RST;
			cfg_q <= `DCPU_CFG_RST;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok_d;
			if (psel && !penable) begin
				prdata <= pwrite ? 32'h00000000 : rdata_d;
			end
			if (psel && penable && pready && pwrite && paddr == `DCPU_ADDR_CTRL) begin
				ctrl_q <= pwdata & `DCPU_CTRL_MASK;
			end
			if (frame_blank && st_q[0] && left_q == 3'h0) begin
				cfg_q <= ctrl_q[7:0];
			end
		end
	end
endmodule

// *** dv/dcpu_props.sv ***
// Checker of the unpacker's bus handshake and pixel stream.
`include "dcpu_regs.vh"
module dcpu_props #(
	parameter BUS_W = 64
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire latch_clock,
	input wire pix_ready,
	input wire pix_valid,
	input wire [7:0] pix_red,
	input wire [7:0] pix_green,
	input wire [7:0] pix_blue,
	input wire [7:0] pix_ovl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mapped;
	logic [3:0] since_q;
	assign mapped = paddr == `DCPU_ADDR_CTRL || paddr == `DCPU_ADDR_STAT || paddr == `DCPU_ADDR_CAPT;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since_q <= 4'hF;
		else if ($rose(latch_clock))
			since_q <= 4'h0;
		else if (since_q != 4'hF)
			since_q <= since_q + 4'h1;
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	chk_ready_next: assert property (s_setup |=> pready)
		else $error("No answer after setup.");
	chk_ready_phase: assert property (pready |-> s_access ##0 $past(!penable))
		else $error("Answer outside first access cycle.");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("Answer held too long.");
	chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
		else $error("Unmapped access not refused.");
	chk_err_mapped: assert property (pready && mapped |-> !pslverr)
		else $error("Mapped access refused.");
	chk_err_alone: assert property (pslverr |-> pready)
		else $error("Error without answer.");
	chk_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("Refused read returned data.");
	chk_stall_hold: assert property (pix_valid && !pix_ready |=> pix_valid &&
		$stable({pix_red, pix_green, pix_blue, pix_ovl}))
		else $error("Pixel changed during stall.");
	chk_valid_cause: assert property ($rose(pix_valid) |-> since_q <= 4'hA)
		else $error("Pixel without latch edge.");
endmodule

// *** dv/dcpu_fb_model.sv ***
// Frame buffer model driving the pixel bus and the latch clock.
module dcpu_fb_model (
	input wire pclk,
	output logic latch_clock,
	output logic [63:0] pixel_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		latch_clock = 1'b0;
		pixel_bus = 64'h0;
	end
	// The bus is seen after the board wiring, which reverses it in big-endian systems.
	task automatic send(input logic [63:0] w);
		begin
			@(posedge pclk);
			pixel_bus <= w;
			latch_clock <= 1'b1;
			repeat (3) @(posedge pclk);
			latch_clock <= 1'b0;
			repeat (3) @(posedge pclk);
			pixel_bus <= ~w;
		end
	endtask
endmodule

// *** dv/tb_direct_color_pixel_unpacker.sv ***
// Testbench of the pixel unpacker.
`include "dcpu_regs.vh"
module tb_direct_color_pixel_unpacker;
	timeunit 1ns;
	timeprecision 1ps;
	localparam BUS_W = 64;
	logic pclk, presetn, psel, penable, pwrite, frame_blank, pix_ready;
	logic pready, pslverr, latch_clock, pix_valid, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] pixel_bus;
	logic [7:0] pix_red, pix_green, pix_blue, pix_ovl, cur;
	logic [31:0] got[$];
	int error_cnt, cmp_count, cyc, caps;
	logic [63:0] lay_map [12] = '{64'h0808100818080008, 64'h1008080800081808,
		64'h0B05050600050000, 64'h0A05050500050F01, 64'h0A06040600040000,
		64'h0C04080404040004, 64'h0808100818080008, 64'h1008080800081808,
		64'h000505060B050000, 64'h010506050B050001, 64'h000606060C040000,
		64'h0004040408040C04};
	dcpu_top #(.BUS_W(BUS_W)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .latch_clock, .pixel_bus, .frame_blank, .pix_ready,
		.pix_valid, .pix_red, .pix_green, .pix_blue, .pix_ovl);
	dcpu_fb_model fb (.pclk, .latch_clock, .pixel_bus);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report();
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [7:0] ext(input logic [63:0] s, input logic [15:0] f);
		logic [7:0] v, r;
		v = 8'(s >> f[15:8]) & 8'((9'h1 << f[7:0]) - 9'h1);
		r = 8'h00;
		for (int k = 0; k < f[7:0]; k++)
			r[7 - k] = cur[5] ? v[k] : v[f[7:0] - 1 - k];
		return r;
	endfunction
	function automatic logic [31:0] exp_pix(input logic [63:0] w, input int i, input int sz);
		logic [63:0] s, m;
		s = (w & ~(64'hFFFFFFFFFFFFFFFF << (16 << cur[4:3]))) >> (i * sz);
		m = lay_map[cur[5] * 6 + cur[2:0]];
		return {ext(s, m[63:48]), ext(s, m[47:32]), ext(s, m[31:16]),
			cur[6] ? 8'h00 : ext(s, m[15:0])};
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			error_cnt++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cfg(input logic [7:0] c);
		apb(1'b1, `DCPU_ADDR_CTRL, {24'h0, c});
		frame_blank <= 1'b1;
		repeat (3) @(posedge pclk);
		frame_blank <= 1'b0;
		cur = c;
	endtask
	task automatic run();
		logic [63:0] w;
		int n, k, sz;
		w = {$urandom, $urandom};
		got.delete();
		if (cur[7])
			caps++;
		fb.send(w);
		sz = cur[2:0] < 2 ? 32 : 16;
		n = (!cur[7] || cur[2:0] > 5) ? 0 : ((16 << cur[4:3]) + sz - 1) / sz;
		for (k = 0; got.size() < n && k < 60; k++)
			@(posedge pclk);
		repeat (4) @(posedge pclk);
		chk(got.size(), n);
		for (int i = 0; i < got.size() && i < n; i++)
			chk(got[i], exp_pix(w, i, sz));
	endtask
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		pix_ready <= ($urandom % 4) != 0;
		if (pix_valid === 1'b1 && pix_ready === 1'b1)
			got.push_back({pix_red, pix_green, pix_blue, pix_ovl});
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		frame_blank = 1'b0;
		void'($urandom(32'h0591));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `DCPU_ADDR_CTRL, 32'h0);
		chk(rd, `DCPU_CTRL_RST);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		cur = 8'(`DCPU_CTRL_RST);
		run();
		for (int wd = 0; wd < 3; wd++)
			for (int be = 0; be < 2; be++)
				for (int lay = 0; lay < 6; lay++) begin
					cfg({1'b1, 1'($urandom), 1'(be), 2'(wd), 3'(lay)});
					run();
					run();
				end
		apb(1'b1, `DCPU_ADDR_CTRL, 32'h0);
		run();
		apb(1'b0, `DCPU_ADDR_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `DCPU_ADDR_STAT, 32'hFFFFFFFF);
		chk({31'h0, er}, 32'h0);
		apb(1'b0, `DCPU_ADDR_STAT, 32'h0);
		chk(rd, {24'h0, cur});
		apb(1'b0, `DCPU_ADDR_CAPT, 32'h0);
		chk(rd, caps);
		cfg(8'h00);
		run();
		final_report();
	end
endmodule
bind dcpu_top dcpu_props #(.BUS_W(BUS_W)) u_props (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .latch_clock, .pix_ready, .pix_valid, .pix_red,
	.pix_green, .pix_blue, .pix_ovl);
